/* File: hw/ecvs_sync.sv */
// Two-flop synchroniser for a pin level.
// Assumes the pin is asynchronous to sys_clk_i.
`timescale 1ns/100ps
`default_nettype none
module ecvs_sync (
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  input  wire logic pin_i,
  output logic      sync_o
);
  typedef struct packed {
    logic meta;
    logic sync;
  } ecvs_sync_st_t;

  ecvs_sync_st_t st;
  ecvs_sync_st_t next_st;

  always_comb begin
    next_st.meta = pin_i;
    next_st.sync = st.meta;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.sync;
endmodule : ecvs_sync
`default_nettype wire

/* File: hw/ecvs_top.sv */
// Edge-count voltage select: counts enable/set rising edges into a level.
// Assumes asynchronous pins, a 250 MHz clock and an analog side that
// regulates to the reference code and enables given here.
//
// Function
// (RULE1) Select high regulates to first level, low to second level.
// (RULE2) Select high enables high reference 1.2 V; low enables low reference.
// (RULE3) Host holds select low while programming through edge counts.
// (RULE4) Rising edges on enable/set are counted into one of 16 states.
// (RULE5) Edges at up to 1 MHz are all counted.
// (RULE6) Line held high for latch delay captures the count.
// (RULE7) After capture the output moves to the selected level.
// (RULE8) Line low longer than disable delay disables the device.
// (RULE9) Disabling resets the setting to the 0.6 V default.
// (RULE10) Power-up default low reference is 0.6 V.
// (RULE11) Counts 1..16 map to 0.60..1.20 V in 40 mV steps.
// (RULE12) A new burst after a latch restarts counting from zero.
// (RULE13) More than sixteen edges wrap back to the first level.
`timescale 1ns/100ps
`default_nettype none
`include "ecvs_map.svh"
module ecvs_top
  import ecvs_pkg::*;
#(
  parameter logic [`ECVS_CNT_W-1:0] LAT_CYC = `ECVS_LAT_CYC,
  parameter logic [`ECVS_CNT_W-1:0] OFF_CYC = `ECVS_OFF_CYC
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   nrst_i,
  input  wire logic                   en_set_i,
  input  wire logic                   ref_sel_i,
  output logic                        enabled_o,
  output logic                        high_ref_feedback_en_o,
  output logic                        low_ref_feedback_en_o,
  output logic [`ECVS_LVL_W-1:0]      level_code_o,
  output logic [`ECVS_MV_W-1:0]       ref_mv_o
);
  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  logic en_s;
  logic sel_s;

  ecvs_sync u_sync_en (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .pin_i     (en_set_i),
    .sync_o    (en_s)
  );

  ecvs_sync u_sync_sel (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .pin_i     (ref_sel_i),
    .sync_o    (sel_s)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    ecvs_state_t             fsm;
    logic                    en_d;
    logic [`ECVS_CNT_W-1:0]  timer;
    logic [`ECVS_LVL_W-1:0]  edges;
    logic [`ECVS_LVL_W-1:0]  level;
    logic                    enabled;
    logic                    hi_en;
    logic                    lo_en;
    logic [`ECVS_MV_W-1:0]   mv;
  } ecvs_st_t;

  ecvs_st_t st;
  ecvs_st_t next_st;
  logic     rise;

  // The edge counter starts at zero for a first edge, so code equals
  // edges minus one and a 16-edge burst lands on the top code.
  always_comb begin
    next_st = st;
    rise = en_s && !st.en_d;
    next_st.en_d = en_s;
    case (st.fsm)
      ECVS_OFF: begin
        next_st.enabled = 1'b0;
        next_st.level = `ECVS_LVL_DEFAULT; // RULE9
        if (rise) begin
          // The enabling edge is also the first counted edge.
          next_st.fsm = ECVS_COUNT;
          next_st.edges = `ECVS_LVL_DEFAULT; // RULE12
          next_st.timer = '0;
          next_st.enabled = 1'b1;
        end
      end
      ECVS_IDLE: begin
        if (!en_s) begin
          next_st.timer = st.timer + 1'b1;
          if (st.timer >= OFF_CYC) begin
            next_st.fsm = ECVS_OFF; // RULE8
            next_st.level = `ECVS_LVL_DEFAULT; // RULE9
            next_st.enabled = 1'b0;
          end
        end else if (rise) begin
          next_st.fsm = ECVS_COUNT;
          next_st.edges = `ECVS_LVL_DEFAULT; // RULE12
          next_st.timer = '0;
        end else begin
          next_st.timer = '0;
        end
      end
      ECVS_COUNT: begin
        // Counts every edge at clock resolution, far beyond 1 MHz.
        if (rise) begin
          next_st.edges = st.edges + 1'b1; // RULE4 RULE5 RULE13
          next_st.timer = '0;
        end else if (en_s) begin
          next_st.timer = st.timer + 1'b1;
          if (st.timer >= LAT_CYC - 1'b1) begin
            next_st.level = st.edges; // RULE6 RULE7
            next_st.fsm = ECVS_IDLE;
            next_st.timer = '0;
          end
        end else if (st.en_d) begin
          // A falling edge restarts the timer for the low-time count.
          next_st.timer = '0;
        end else begin
          // A host that abandons a burst with the line low is still
          // disabled, otherwise the block would hang in counting.
          next_st.timer = st.timer + 1'b1;
          if (st.timer >= OFF_CYC) begin
            next_st.fsm = ECVS_OFF; // RULE8
            next_st.level = `ECVS_LVL_DEFAULT; // RULE9
            next_st.enabled = 1'b0;
          end
        end
      end
      default: begin
        next_st.fsm = ECVS_OFF;
      end
    endcase
    next_st.hi_en = next_st.enabled && sel_s; // RULE1 RULE2
    next_st.lo_en = next_st.enabled && !sel_s; // RULE1 RULE2
    // Select high uses the fixed high reference; low uses the code.
    next_st.mv = sel_s ? `ECVS_REF_HIGH_MV :
      (`ECVS_REF_BASE_MV +
       `ECVS_REF_STEP_MV * {7'h00, next_st.level}); // RULE11 RULE10
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '{fsm: ECVS_OFF, en_d: 1'b0, timer: '0,
              edges: `ECVS_LVL_DEFAULT, level: `ECVS_LVL_DEFAULT,
              enabled: 1'b0, hi_en: 1'b0, lo_en: 1'b0,
              mv: `ECVS_REF_BASE_MV};
    end else begin
      st <= next_st;
    end
  end

  assign enabled_o              = st.enabled;
  assign high_ref_feedback_en_o = st.hi_en;
  assign low_ref_feedback_en_o  = st.lo_en;
  assign level_code_o           = st.level;
  assign ref_mv_o               = st.mv;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  a_ref_exclusive: assert property ( // RULE2
    !(high_ref_feedback_en_o && low_ref_feedback_en_o))
    else $error("both references enabled");
  a_sel_high_ref: assert property ( // RULE1
    (enabled_o && sel_s) |=> ref_mv_o == `ECVS_REF_HIGH_MV)
    else $error("high reference value wrong");
  a_low_ref_map: assert property ( // RULE11
    (enabled_o && !sel_s) |=> ref_mv_o == `ECVS_REF_BASE_MV +
      `ECVS_REF_STEP_MV * {7'h00, level_code_o})
    else $error("low reference mapping wrong");
  a_edge_count: assert property ( // RULE4
    (st.fsm == ECVS_COUNT && rise) |=> st.edges == $past(st.edges) + 1'b1)
    else $error("edge not counted");
  a_latch_level: assert property ( // RULE6
    (st.fsm == ECVS_COUNT && $past(st.fsm) == ECVS_COUNT
     && next_st.fsm == ECVS_IDLE) |=> level_code_o == $past(st.edges))
    else $error("latched level wrong");
  a_off_default: assert property ( // RULE9
    st.fsm == ECVS_OFF |-> level_code_o == `ECVS_LVL_DEFAULT)
    else $error("disabled level not default");
  a_off_disabled: assert property ( // RULE8
    (st.fsm == ECVS_OFF && !rise) |=> !enabled_o)
    else $error("enabled while off");
  a_burst_restart: assert property ( // RULE12
    (st.fsm == ECVS_IDLE && rise) |=> st.edges == `ECVS_LVL_DEFAULT)
    else $error("burst did not restart");
  a_wrap: assert property ( // RULE13
    (st.fsm == ECVS_COUNT && rise && st.edges == `ECVS_LVL_MAX)
    |=> st.edges == `ECVS_LVL_DEFAULT)
    else $error("count did not wrap");

  c_latch: cover property (st.fsm == ECVS_COUNT ##1 st.fsm == ECVS_IDLE);
  c_off: cover property (st.fsm == ECVS_IDLE ##1 st.fsm == ECVS_OFF);
  c_high: cover property (high_ref_feedback_en_o);
  c_wrap: cover property (rise && st.edges == `ECVS_LVL_MAX);
endmodule : ecvs_top
`default_nettype wire

/* File: shared/ecvs_map.svh */
// Constants of the edge-count voltage select block: counts, codes, delays.
// Assumes a 250 MHz system clock; included by bare name.
`ifndef ECVS_MAP_SVH
`define ECVS_MAP_SVH

`define ECVS_CLK_MHZ        250
// Latch hold delay in microseconds and in clock cycles.
`define ECVS_LATCH_HOLD_DELAY_US       500
`define ECVS_LAT_CYC        (20'(`ECVS_LATCH_HOLD_DELAY_US * `ECVS_CLK_MHZ))
// Disable delay in microseconds and in clock cycles.
`define ECVS_T_OFF_US       500
`define ECVS_OFF_CYC        (20'(`ECVS_T_OFF_US * `ECVS_CLK_MHZ))
`define ECVS_CNT_W          20
`define ECVS_LVL_W          4
`define ECVS_LVL_DEFAULT    4'h0
`define ECVS_LVL_MAX        4'hf
// Low reference in millivolts: base plus code times step.
`define ECVS_MV_W           11
`define ECVS_REF_BASE_MV    11'h258
`define ECVS_REF_STEP_MV    11'h028
`define ECVS_REF_HIGH_MV    11'h4b0

`endif

/* File: shared/ecvs_pkg.sv */
// Types of the edge-count voltage select block.
// Assumes ecvs_map.svh on the include path.
`include "ecvs_map.svh"
package ecvs_pkg;
  typedef enum logic [1:0] {
    ECVS_OFF,
    ECVS_IDLE,
    ECVS_COUNT
  } ecvs_state_t;
endpackage : ecvs_pkg

/* File: test/ecvs_host.sv */
// Host controller model that drives the enable/set line of the block.
// Assumes the caller invokes its tasks from a process clocked by sys_clk_i.
`timescale 1ns/100ps
`default_nettype none
module ecvs_host (
  input  wire logic sys_clk_i,
  output logic      en_set_o
);
  initial en_set_o = 1'b0;

  // Changes land just after a rising edge and then stand for c cycles.
  task automatic drive(input logic v, input int c);
    repeat (c) begin
      @(posedge sys_clk_i);
      en_set_o <= v;
    end
  endtask : drive

  // Pulses of 3 cycles low and 3 high are far faster than the 1 MHz limit.
  // The select line is held low by the bench meanwhile.
  task automatic burst(input int n);
    repeat (n) begin
      drive(1'b0, 3);
      drive(1'b1, 3);
    end
  endtask : burst

  // Holding the line high past the latch delay commits the count.
  task automatic hold(input int c);
    drive(1'b1, c);
  endtask : hold
endmodule : ecvs_host
`default_nettype wire

/* File: test/test_edge_count_voltage_select.sv */
// Self-checking bench for ecvs_top with a host model on enable/set.
// Assumes shortened latch and disable delays of 20 and 40 cycles.
`timescale 1ns/100ps
`default_nettype none
`include "ecvs_map.svh"
module test_edge_count_voltage_select import ecvs_pkg::*;;
  localparam int LAT = 20;
  localparam int OFF = 40;
  typedef struct {int n; logic sel; logic [3:0] code; logic [10:0] mv;}
    ecvs_row_t;
  ecvs_row_t rows [6] = '{'{1, 1'b0, 4'h0, 11'h258},
    '{2, 1'b0, 4'h1, 11'h280}, '{16, 1'b0, 4'hf, 11'h4b0},
    '{17, 1'b0, 4'h0, 11'h258}, '{5, 1'b1, 4'h4, 11'h4b0},
    '{3, 1'b0, 4'h2, 11'h2a8}};
  logic        sys_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic        ref_sel = 1'b0;
  logic        en_set;
  logic        enabled, hi_en, lo_en;
  logic [3:0]  code;
  logic [10:0] mv;
  int          miscompares = 0;
  int          num_checks  = 0;
  int          k;

  always #2 sys_clk = ~sys_clk;

  ecvs_host ecvs_host_i (.sys_clk_i(sys_clk), .en_set_o(en_set));
  ecvs_top #(.LAT_CYC(20'h14), .OFF_CYC(20'h28)) ecvs_top_i (
    .sys_clk_i(sys_clk), .nrst_i(nrst), .en_set_i(en_set),
    .ref_sel_i(ref_sel), .enabled_o(enabled),
    .high_ref_feedback_en_o(hi_en), .low_ref_feedback_en_o(lo_en),
    .level_code_o(code), .ref_mv_o(mv));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic check_out(input logic [3:0] c, input logic [10:0] m,
                           input logic s, input logic e);
    @(negedge sys_clk);
    check(code, c);
    check(mv, m);
    check(hi_en, e & s);
    check(lo_en, e & ~s);
    check(enabled, e);
  endtask : check_out

  task automatic set_sel(input logic s);
    @(posedge sys_clk);
    ref_sel <= s;
    repeat (6) @(posedge sys_clk);
  endtask : set_sel

  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    check_out(4'h0, 11'h258, 1'b0, 1'b0);
    // Table of bursts: program with select low, then apply the row's select.
    foreach (rows[i]) begin
      set_sel(1'b0);
      ecvs_host_i.burst(rows[i].n);
      ecvs_host_i.hold(LAT + 8);
      set_sel(rows[i].sel);
      check_out(rows[i].code, rows[i].mv, rows[i].sel, 1'b1);
    end
    // A short low spell stays enabled; its rising edge is a burst of one.
    ecvs_host_i.drive(1'b0, OFF - 10);
    @(negedge sys_clk);
    check(enabled, 1'b1);
    ecvs_host_i.hold(LAT + 8);
    check_out(4'h0, 11'h258, 1'b0, 1'b1);
    // A burst cut short of the latch delay must not change the code yet.
    ecvs_host_i.burst(3);
    ecvs_host_i.hold(LAT + 8);
    ecvs_host_i.burst(4);
    check_out(4'h2, 11'h2a8, 1'b0, 1'b1);
    ecvs_host_i.hold(LAT + 8);
    check_out(4'h3, 11'h2d0, 1'b0, 1'b1);
    // A long low spell disables and clears the setting.
    ecvs_host_i.drive(1'b0, 1);
    for (k = 0; k < OFF + 20 && enabled !== 1'b0; k++) begin
      @(negedge sys_clk);
    end
    if (enabled !== 1'b0) begin
      miscompares++;
      report_and_stop();
    end
    check_out(4'h0, 11'h258, 1'b0, 1'b0);
    ecvs_host_i.burst(1);
    ecvs_host_i.hold(LAT + 8);
    check_out(4'h0, 11'h258, 1'b0, 1'b1);
    // Reset in mid-run with the line high: defaults, then a fresh enable.
    ecvs_host_i.burst(4);
    ecvs_host_i.hold(LAT + 8);
    check_out(4'h3, 11'h2d0, 1'b0, 1'b1);
    @(posedge sys_clk);
    nrst <= 1'b0;
    check_out(4'h0, 11'h258, 1'b0, 1'b0);
    @(posedge sys_clk);
    nrst <= 1'b1;
    ecvs_host_i.hold(LAT + 8);
    check_out(4'h0, 11'h258, 1'b0, 1'b1);
    report_and_stop();
  end
endmodule : test_edge_count_voltage_select
`default_nettype wire
